// File: core/asc_defines.vh
// register offsets, field positions and constants for the converter sequencer
`ifndef ASC_DEFINES_VH
`define ASC_DEFINES_VH
// register byte offsets
`define ASC_STATUS_OFF 6'h00
`define ASC_IRQEN_OFF 6'h04
`define ASC_CTRL_OFF 6'h08
`define ASC_CFG1_OFF 6'h0C
`define ASC_CFG3_OFF 6'h18
`define ASC_CCFG_OFF 6'h1C
`define ASC_CHSEL_OFF 6'h28
`define ASC_RESULT_OFF 6'h30
// control register bits
`define ASC_CTRL_EN 0
`define ASC_CTRL_START 2
`define ASC_CTRL_CAL 31
// status bits
`define ASC_ST_EOC 2
`define ASC_ST_EOS 3
// configuration register one fields
`define ASC_CFG1_TSEL_LO 6
`define ASC_CFG1_ESEL_LO 10
`define ASC_CFG1_CONT 13
`define ASC_CFG1_ONECH 16
// configuration register three fields
`define ASC_CFG3_T2_LO 0
`define ASC_CFG3_E2_LO 4
`define ASC_CFG3_T3_LO 8
`define ASC_CFG3_E3_LO 12
// common configuration
`define ASC_CCFG_TS 23
// trigger codes and edge modes
`define ASC_TRIG_MAX 4'h9
`define ASC_EDGE_OFF 2'h0
`define ASC_EDGE_RISE 2'h1
`define ASC_EDGE_FALL 2'h2
`define ASC_EDGE_BOTH 2'h3
// fixed internal channels
`define ASC_CH_TEMP 5'h10
`define ASC_CH_VREF 5'h11
`define ASC_CH_HALF 5'h12
`define ASC_NUM_CH 19
// axi responses
`define ASC_RESP_OK 2'h0
`define ASC_RESP_SLVERR 2'h2
`endif

// File: core/asc_adc_sequencer_control.v
// sequencer and control logic for a successive-approximation converter
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
// Overview of operation
// - writing calibrate_request while disabled and idle starts calibration; hardware clears it when done.
// - start requests are ignored while calibration runs.
// - calibration_factor appears in result bits 6:0 after calibration.
// - repeat_mode_select 0 with one_channel_per_trigger 0 converts channel or group once, then stops.
// - repeat_mode_select 1 with one_channel_per_trigger 0 keeps converting the group after one start.
// - conversion starts on start_conversion write or enabled hardware trigger.
// - each channel result stored, conversion_done_flag set, irq if enabled.
// - last channel sets sequence_done_flag, irq if enabled.
// - one_channel_per_trigger 1 converts one next channel per trigger.
// - one_channel_per_trigger 0 converts whole sequence per trigger.
// - channels 0 to 15 route to the external analog inputs.
// - channel 16 temperature, 17 internal reference, 18 half supply.
// - temperature sensor connected only when temp_sensor_enable is set.
// - seg1_trigger_select picks timer trigger 0 to 9; above is reserved.
// - edge select 00 off, 01 rising, 10 falling, 11 both.
// - a trigger starts only with nonzero edge select, on its edges.
// - segment two has own trigger and edge select in register three.
// - segment three has own trigger and edge select in register three.
`include "asc_defines.vh"
module asc_adc_sequencer_control #(
   parameter NTRIG = 10,
   parameter SEQ_LEN_W = 4
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // axi4-lite write address and data
   input wire [5:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read
   input wire [5:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // timer trigger outputs
   input wire [NTRIG-1:0] timer_trig,
   // analog core handshake
   output reg core_cal_start,
   input wire core_cal_done,
   input wire [6:0] core_cal_factor,
   output reg core_conv_start,
   output reg [4:0] core_channel,
   input wire core_conv_done,
   input wire [15:0] core_result,
   output wire temp_sensor_connect,
   output wire [15:0] ext_input_select,
   output wire vref_select,
   output wire half_supply_select,
   // interrupt
   output wire irq
);
   localparam ST_IDLE = 2'h0;
   localparam ST_CAL = 2'h1;
   localparam ST_CONV = 2'h2;
   localparam ST_WAIT = 2'h3;

   reg [1:0] state_q;
   reg en_q, cal_q, start_q, eoc_q, eos_q, eoc_ie_q, eos_ie_q, ts_q;
   reg [31:0] cfg1_q, cfg3_q;
   reg [5*8-1:0] chsel_q;
   reg [SEQ_LEN_W-1:0] seq_len_q, idx_q;
   reg [15:0] result_q;
   reg aw_hold_q, w_hold_q;
   reg [5:0] aw_addr_q;
   reg [31:0] w_data_q;

   // write channel: address and data caught independently
   assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
   wire aw_now = s_axi_awvalid && s_axi_awready;
   wire w_now = s_axi_wvalid && s_axi_wready;
   wire have_aw = aw_hold_q || aw_now;
   wire have_w = w_hold_q || w_now;
   wire [5:0] waddr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
   wire [31:0] wdata = w_hold_q ? w_data_q : s_axi_wdata;
   wire wr_fire = have_aw && have_w && !s_axi_bvalid;
   wire wr_ctrl = wr_fire && waddr == `ASC_CTRL_OFF;
   wire wr_stat = wr_fire && waddr == `ASC_STATUS_OFF;
   wire wr_known = waddr == `ASC_STATUS_OFF || waddr == `ASC_IRQEN_OFF ||
      waddr == `ASC_CTRL_OFF || waddr == `ASC_CFG1_OFF ||
      waddr == `ASC_CFG3_OFF || waddr == `ASC_CCFG_OFF ||
      waddr == `ASC_CHSEL_OFF || waddr == `ASC_RESULT_OFF;

   // trigger synchronisers and edge detection per segment
   reg [NTRIG-1:0] trg_s1_q, trg_s2_q, trg_s3_q;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         trg_s1_q <= {NTRIG{1'b0}};
         trg_s2_q <= {NTRIG{1'b0}};
         trg_s3_q <= {NTRIG{1'b0}};
      end else begin
         trg_s1_q <= timer_trig;
         trg_s2_q <= trg_s1_q;
         trg_s3_q <= trg_s2_q;
      end
   end

   wire [4*3-1:0] seg_tsel = {cfg3_q[`ASC_CFG3_T3_LO +: 4],
      cfg3_q[`ASC_CFG3_T2_LO +: 4], cfg1_q[`ASC_CFG1_TSEL_LO +: 4]};
   wire [2*3-1:0] seg_esel = {cfg3_q[`ASC_CFG3_E3_LO +: 2],
      cfg3_q[`ASC_CFG3_E2_LO +: 2], cfg1_q[`ASC_CFG1_ESEL_LO +: 2]};
   wire [2:0] seg_hit;
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_seg
         wire [3:0] ts = seg_tsel[4*g +: 4];
         wire [1:0] es = seg_esel[2*g +: 2];
         // reserved codes select nothing
         wire valid = ts <= `ASC_TRIG_MAX;
         wire cur = valid && trg_s2_q[ts];
         wire prv = valid && trg_s3_q[ts];
         assign seg_hit[g] =
            (es == `ASC_EDGE_RISE && cur && !prv) ||
            (es == `ASC_EDGE_FALL && !cur && prv) ||
            (es == `ASC_EDGE_BOTH && cur != prv);
      end
   endgenerate
   wire hw_start = |seg_hit;

   wire sw_start = wr_ctrl && wdata[`ASC_CTRL_START];
   // starts only count when enabled and not calibrating
   wire start_req = (sw_start || hw_start) && en_q &&
      state_q != ST_CAL;
   wire cal_req = wr_ctrl && wdata[`ASC_CTRL_CAL] && !en_q &&
      state_q == ST_IDLE;
   wire last_ch = idx_q == seq_len_q;
   wire cont = cfg1_q[`ASC_CFG1_CONT];
   wire onech = cfg1_q[`ASC_CFG1_ONECH];
   wire conv_ok = state_q == ST_CONV && core_conv_done;
   wire [4:0] cur_ch = chsel_q[5*idx_q[2:0] +: 5];

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         en_q <= 1'b0;
         cal_q <= 1'b0;
         start_q <= 1'b0;
         eoc_q <= 1'b0;
         eos_q <= 1'b0;
         eoc_ie_q <= 1'b0;
         eos_ie_q <= 1'b0;
         ts_q <= 1'b0;
         cfg1_q <= 32'h0000_0000;
         cfg3_q <= 32'h0000_0000;
         chsel_q <= 40'h00_0000_0000;
         seq_len_q <= {SEQ_LEN_W{1'b0}};
         idx_q <= {SEQ_LEN_W{1'b0}};
         result_q <= 16'h0000;
         core_cal_start <= 1'b0;
         core_conv_start <= 1'b0;
         core_channel <= 5'h00;
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_addr_q <= 6'h00;
         w_data_q <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ASC_RESP_OK;
      end else begin
         core_cal_start <= 1'b0;
         core_conv_start <= 1'b0;
         if (aw_now && !wr_fire) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_now && !wr_fire) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (wr_fire) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `ASC_RESP_OK : `ASC_RESP_SLVERR;
            case (waddr)
               `ASC_IRQEN_OFF: begin
                  eoc_ie_q <= wdata[`ASC_ST_EOC];
                  eos_ie_q <= wdata[`ASC_ST_EOS];
               end
               `ASC_CTRL_OFF: en_q <= wdata[`ASC_CTRL_EN];
               `ASC_CFG1_OFF: cfg1_q <= wdata;
               `ASC_CFG3_OFF: cfg3_q <= wdata;
               `ASC_CCFG_OFF: ts_q <= wdata[`ASC_CCFG_TS];
               `ASC_CHSEL_OFF: begin
                  chsel_q <= {10'h000, wdata[29:0]};
                  seq_len_q <= wdata[31:28];
               end
               default: ;
            endcase
         end
         // write one clears; a same-cycle hardware set wins below
         if (wr_stat && wdata[`ASC_ST_EOC])
            eoc_q <= 1'b0;
         if (wr_stat && wdata[`ASC_ST_EOS])
            eos_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (cal_req) begin
                  cal_q <= 1'b1;
                  core_cal_start <= 1'b1;
                  state_q <= ST_CAL;
               end else if (start_req) begin
                  // a fresh start begins at the first slot; a group cut
                  // short by disabling would otherwise resume mid-way
                  start_q <= 1'b1;
                  idx_q <= {SEQ_LEN_W{1'b0}};
                  core_channel <= chsel_q[4:0];
                  core_conv_start <= 1'b1;
                  state_q <= ST_CONV;
               end
            end
            ST_CAL: begin
               if (core_cal_done) begin
                  cal_q <= 1'b0;
                  result_q <= {9'h000, core_cal_factor};
                  state_q <= ST_IDLE;
               end
            end
            ST_CONV: begin
               if (core_conv_done) begin
                  result_q <= core_result;
                  eoc_q <= 1'b1;
                  if (last_ch) begin
                     eos_q <= 1'b1;
                     idx_q <= {SEQ_LEN_W{1'b0}};
                  end else begin
                     idx_q <= idx_q + 1'b1;
                  end
                  if (!en_q) begin
                     start_q <= 1'b0;
                     state_q <= ST_IDLE;
                  end else if (onech) begin
                     start_q <= 1'b0;
                     state_q <= ST_WAIT;
                  end else if (last_ch && !cont) begin
                     start_q <= 1'b0;
                     state_q <= ST_IDLE;
                  end else begin
                     core_conv_start <= 1'b1;
                     core_channel <= chsel_q[5*(last_ch ? 3'h0 :
                        idx_q[2:0] + 3'h1) +: 5];
                  end
               end
            end
            ST_WAIT: begin
               // next trigger converts the next channel only
               if (start_req) begin
                  start_q <= 1'b1;
                  core_channel <= cur_ch;
                  core_conv_start <= 1'b1;
                  state_q <= ST_CONV;
               end else if (!en_q) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // channel routing to the analog multiplexer
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_ext
         assign ext_input_select[g] = state_q == ST_CONV &&
            core_channel == g;
      end
   endgenerate
   assign temp_sensor_connect = ts_q && state_q == ST_CONV &&
      core_channel == `ASC_CH_TEMP;
   assign vref_select = state_q == ST_CONV &&
      core_channel == `ASC_CH_VREF;
   assign half_supply_select = state_q == ST_CONV &&
      core_channel == `ASC_CH_HALF;
   assign irq = (eoc_q && eoc_ie_q) || (eos_q && eos_ie_q);

   // read channel
   assign s_axi_arready = !s_axi_rvalid;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `ASC_RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `ASC_RESP_OK;
         s_axi_rdata <= 32'h0000_0000;
         case (s_axi_araddr)
            `ASC_STATUS_OFF: begin
               s_axi_rdata[`ASC_ST_EOC] <= eoc_q;
               s_axi_rdata[`ASC_ST_EOS] <= eos_q;
            end
            `ASC_IRQEN_OFF: begin
               s_axi_rdata[`ASC_ST_EOC] <= eoc_ie_q;
               s_axi_rdata[`ASC_ST_EOS] <= eos_ie_q;
            end
            `ASC_CTRL_OFF: begin
               s_axi_rdata[`ASC_CTRL_EN] <= en_q;
               s_axi_rdata[`ASC_CTRL_START] <= start_q;
               s_axi_rdata[`ASC_CTRL_CAL] <= cal_q;
            end
            `ASC_CFG1_OFF: s_axi_rdata <= cfg1_q;
            `ASC_CFG3_OFF: s_axi_rdata <= cfg3_q;
            `ASC_CCFG_OFF: s_axi_rdata[`ASC_CCFG_TS] <= ts_q;
            // the last-index field in bits 31:28 shares bits 29:28 with slot five (bits 29:25)
            `ASC_CHSEL_OFF: s_axi_rdata <= {seq_len_q, chsel_q[27:0]};
            `ASC_RESULT_OFF: s_axi_rdata <= {16'h0000, result_q};
            default: s_axi_rresp <= `ASC_RESP_SLVERR;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // asc_adc_sequencer_control

// File: tb/asc_checker.sv
// port-level concurrent checks for the converter sequencer
`timescale 1ns/100ps
module asc_checker (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // bus answers
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   // analog core side
   input wire core_cal_start,
   input wire core_cal_done,
   input wire core_conv_start,
   input wire [4:0] core_channel,
   input wire temp_sensor_connect,
   input wire [15:0] ext_input_select,
   input wire vref_select,
   input wire half_supply_select
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   sequence s_cal_end;
      ##[0:200] core_cal_done;
   endsequence
   sequence s_one_pulse;
      core_conv_start ##1 !core_conv_start;
   endsequence
   chk_ext_map: assert property (
      ext_input_select != 16'h0000 |-> core_channel < 5'h10 &&
      ext_input_select == 16'h0001 << core_channel)
      else $error("external select does not match channel");
   chk_vref_map: assert property (
      vref_select |-> core_channel == 5'h11)
      else $error("reference select on wrong channel");
   chk_half_map: assert property (
      half_supply_select |-> core_channel == 5'h12)
      else $error("half supply select on wrong channel");
   chk_temp_map: assert property (
      temp_sensor_connect |-> core_channel == 5'h10)
      else $error("temperature sensor on wrong channel");
   chk_cal_quiet: assert property (
      core_cal_start |=> !core_conv_start throughout s_cal_end)
      else $error("conversion during calibration");
   chk_start_pulse: assert property (
      core_conv_start |-> s_one_pulse)
      else $error("conversion start longer than one cycle");
   chk_b_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_r_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   chk_r_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
endmodule // asc_checker
bind asc_adc_sequencer_control asc_checker u_asc_checker (.*);

// File: tb/asc_core_model.sv
// behavioural analog core answering calibration and conversion requests
`timescale 1ns/100ps
module asc_core_model #(
   parameter CAL_CYC = 20,
   // software's sampling time is folded into this fixed conversion time
   parameter CONV_CYC = 4,
   parameter CAL_FACTOR = 7'h2a
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // requests
   input wire core_cal_start,
   input wire core_conv_start,
   input wire [4:0] core_channel,
   // answers
   output reg core_cal_done,
   output wire [6:0] core_cal_factor,
   output reg core_conv_done,
   output wire [15:0] core_result
);
   reg [7:0] cal_q;
   reg [7:0] conv_q;
   reg [4:0] ch_q;
   // outside the done cycle show the inverse, so stale sampling is caught
   assign core_cal_factor = core_cal_done ? CAL_FACTOR : ~CAL_FACTOR;
   assign core_result = core_conv_done ? {11'h050, ch_q} : ~{11'h050, ch_q};
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cal_q <= 8'h00;
         conv_q <= 8'h00;
         ch_q <= 5'h00;
         core_cal_done <= 1'b0;
         core_conv_done <= 1'b0;
      end else begin
         core_cal_done <= cal_q == 8'h01;
         core_conv_done <= conv_q == 8'h01;
         cal_q <= core_cal_start ? CAL_CYC : cal_q - (cal_q != 8'h00);
         conv_q <= core_conv_start ? CONV_CYC : conv_q - (conv_q != 8'h00);
         if (core_conv_start) ch_q <= core_channel;
      end
   end
endmodule // asc_core_model

// File: tb/asc_adc_sequencer_control_test.sv
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
`include "asc_defines.vh"
module asc_adc_sequencer_control_test;
   reg core_clk = 1'b0;
   reg rst = 1'b1;
   reg [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   reg [31:0] s_axi_wdata = 32'h0000_0000;
   reg [3:0] s_axi_wstrb = 4'hf;
   reg [9:0] timer_trig = 10'h000;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, core_cal_start, core_cal_done, core_conv_start;
   wire core_conv_done, temp_sensor_connect, vref_select;
   wire half_supply_select, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [6:0] core_cal_factor;
   wire [4:0] core_channel;
   wire [15:0] core_result, ext_input_select;
   integer err_count = 0, checks = 0, cyc_n = 0, ncv = 0, i, j, base;
   reg [31:0] rv;
   reg [1:0] resp;
   reg [4:0] chlog [0:7];
   reg [18:0] sel_q;
   // rows: channel, temperature enable, expected selects
   reg [24:0] rows [0:5];
   always #50 core_clk = ~core_clk;
   asc_adc_sequencer_control u_asc_adc_sequencer_control (.*);
   asc_core_model u_asc_core_model (.*);
   always @(posedge core_clk) begin
      cyc_n <= cyc_n + 1;
      if (core_conv_start) begin
         chlog[ncv[2:0]] <= core_channel;
         ncv <= ncv + 1;
      end
      if (core_conv_done)
         sel_q <= {half_supply_select, vref_select, temp_sensor_connect,
            ext_input_select};
      if (cyc_n == 60000) begin
         err_count = err_count + 1;
         conclude;
      end
   end
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge core_clk);
   endtask
   // ready is judged before the edge; all changes land just after it
   task wr(input [5:0] a, input [31:0] d);
      reg ta, tw, done;
      begin
         @(posedge core_clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         done = 1'b0;
         while (!done) begin
            @(negedge core_clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            done = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (done) s_axi_bready <= 1'b0;
         end
      end
   endtask
   task rd(input [5:0] a);
      reg ta, done;
      begin
         @(posedge core_clk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         done = 1'b0;
         while (!done) begin
            @(negedge core_clk);
            ta = s_axi_arvalid & s_axi_arready;
            done = s_axi_rvalid;
            rv = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge core_clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (done) s_axi_rready <= 1'b0;
         end
      end
   endtask
   task wait_bit(input [5:0] a, input integer b, input v);
      begin
         rv = {32{~v}};
         while (rv[b] !== v) rd(a);
      end
   endtask
   task trig_case(input [31:0] c1, input [31:0] c3, input [9:0] m,
      input integer n);
      begin
         wr(`ASC_CFG1_OFF, c1);
         wr(`ASC_CFG3_OFF, c3);
         base = ncv;
         @(posedge core_clk);
         timer_trig <= m;
         cyc(25);
         timer_trig <= 10'h000;
         cyc(25);
         chk(ncv - base, n);
      end
   endtask
   task conclude;
      begin
         $display("checks %0d err_count %0d", checks, err_count);
         if (err_count == 0 && checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   initial begin
      rows[0] = {5'h00, 1'b0, 19'h0_0001};
      rows[1] = {5'h0f, 1'b0, 19'h0_8000};
      rows[2] = {5'h10, 1'b1, 19'h1_0000};
      rows[3] = {5'h10, 1'b0, 19'h0_0000};
      rows[4] = {5'h11, 1'b0, 19'h2_0000};
      rows[5] = {5'h12, 1'b0, 19'h4_0000};
      cyc(12);
      rst <= 1'b0;
      rd(`ASC_STATUS_OFF);
      chk(rv, 32'h0000_0000);
      rd(`ASC_CTRL_OFF);
      chk(rv, 32'h0000_0000);
      rd(6'h3c);
      chk(resp, `ASC_RESP_SLVERR);
      wr(6'h3c, 32'h0000_0000);
      chk(resp, `ASC_RESP_SLVERR);
      wr(`ASC_CTRL_OFF, 32'h0000_0000);
      chk(resp, `ASC_RESP_OK);
      wr(`ASC_CTRL_OFF, 32'h8000_0000);
      rd(`ASC_CTRL_OFF);
      chk(rv[31], 1);
      // enable, then start twice while calibrating: both must be ignored
      wr(`ASC_CTRL_OFF, 32'h0000_0005);
      wr(`ASC_CTRL_OFF, 32'h0000_0005);
      wait_bit(`ASC_CTRL_OFF, 31, 1'b0);
      chk(ncv, 0);
      rd(`ASC_RESULT_OFF);
      chk(rv[6:0], 7'h2a);
      wr(`ASC_CTRL_OFF, 32'h0000_0001);
      for (i = 0; i < 6; i = i + 1) begin
         wr(`ASC_CCFG_OFF, {8'h00, rows[i][19], 23'h00_0000});
         wr(`ASC_CHSEL_OFF, {27'h000_0000, rows[i][24:20]});
         wr(`ASC_STATUS_OFF, 32'h0000_000c);
         wr(`ASC_CTRL_OFF, 32'h0000_0005);
         wait_bit(`ASC_STATUS_OFF, 2, 1'b1);
         rd(`ASC_RESULT_OFF);
         chk(rv, 32'h0000_0a00 | rows[i][24:20]);
         chk(sel_q, rows[i][18:0]);
         rd(`ASC_STATUS_OFF);
         chk(rv[3], 1);
      end
      cyc(20);
      chk(ncv, 6);
      wr(`ASC_CHSEL_OFF, 32'h2000_1420);
      wr(`ASC_STATUS_OFF, 32'h0000_000c);
      base = ncv;
      wr(`ASC_CTRL_OFF, 32'h0000_0005);
      cyc(60);
      chk(ncv - base, 3);
      for (j = 0; j < 3; j = j + 1)
         chk(chlog[(base + j) % 8], (j == 2) ? 5 : j);
      rd(`ASC_STATUS_OFF);
      chk(rv[3:2], 2'h3);
      wr(`ASC_CFG1_OFF, 32'h0001_0000);
      wr(`ASC_STATUS_OFF, 32'h0000_000c);
      base = ncv;
      for (j = 0; j < 3; j = j + 1) begin
         wr(`ASC_CTRL_OFF, 32'h0000_0005);
         cyc(30);
         chk(ncv - base, j + 1);
         chk(chlog[(base + j) % 8], (j == 2) ? 5 : j);
         rd(`ASC_STATUS_OFF);
         chk(rv[3], j == 2);
      end
      wr(`ASC_CFG1_OFF, 32'h0000_2000);
      base = ncv;
      wr(`ASC_CTRL_OFF, 32'h0000_0005);
      cyc(100);
      chk(ncv - base > 6, 1);
      wr(`ASC_CTRL_OFF, 32'h0000_0000);
      cyc(20);
      base = ncv;
      cyc(40);
      chk(ncv, base);
      wr(`ASC_CHSEL_OFF, 32'h0000_0000);
      wr(`ASC_CTRL_OFF, 32'h0000_0001);
      for (i = 0; i < 4; i = i + 1)
         trig_case({20'h0_0000, i[1:0], 4'h3, 6'h00}, 32'h0000_0000,
            10'h008, (i == 3) ? 2 : (i != 0));
      trig_case(32'h0000_0640, 32'h0000_0000, 10'h200, 1);
      trig_case(32'h0000_0e80, 32'h0000_0000, 10'h3ff, 0);
      trig_case(32'h0000_0000, 32'h0000_0015, 10'h020, 1);
      trig_case(32'h0000_0000, 32'h0000_2700, 10'h080, 1);
      wr(`ASC_CFG3_OFF, 32'h0000_0000);
      wr(`ASC_IRQEN_OFF, 32'h0000_0004);
      wr(`ASC_STATUS_OFF, 32'h0000_000c);
      wr(`ASC_CTRL_OFF, 32'h0000_0005);
      wait_bit(`ASC_STATUS_OFF, 2, 1'b1);
      chk(irq, 1);
      wr(`ASC_IRQEN_OFF, 32'h0000_0000);
      chk(irq, 0);
      wr(`ASC_IRQEN_OFF, 32'h0000_0008);
      chk(irq, 1);
      wr(`ASC_STATUS_OFF, 32'h0000_000c);
      chk(irq, 0);
      conclude;
   end
endmodule // asc_adc_sequencer_control_test
